//--- inc/status_xfer_pkg.sv
/*
 * Constants, field layout and helper functions for the status-register transfer unit.
 * Assumes a 32-bit core datapath and an AXI4-Lite register port with 8-bit addresses.
 */
package status_xfer_pkg;

	// ----------------------------------------------------------------
	// Status word layout
	// ----------------------------------------------------------------
	localparam int unsigned FLAG_HI     = 31;
	localparam int unsigned FLAG_LO     = 28;
	localparam int unsigned IRQ_DIS_BIT = 7;
	localparam int unsigned FIQ_DIS_BIT = 6;
	localparam int unsigned STATE_BIT   = 5;
	localparam int unsigned MODE_HI     = 4;
	localparam logic [31:0] DEFINED_MASK = 32'hF000_00FF;
	localparam logic [31:0] CUR_RESET    = 32'h0000_00D3;
	localparam logic [31:0] SAVED_RESET  = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Processor modes and saved-word banks
	// ----------------------------------------------------------------
	localparam logic [4:0] MODE_USER  = 5'h10;
	localparam logic [4:0] MODE_FIQ   = 5'h11;
	localparam logic [4:0] MODE_IRQ   = 5'h12;
	localparam logic [4:0] MODE_SVC   = 5'h13;
	localparam logic [4:0] MODE_ABORT = 5'h17;
	localparam logic [4:0] MODE_UNDEF = 5'h1B;
	localparam int unsigned NUM_BANKS = 5;

	// ----------------------------------------------------------------
	// Instruction decode fields
	// ----------------------------------------------------------------
	localparam logic [4:0] READ_CLASS  = 5'h02;
	localparam logic [1:0] WRITE_HI    = 2'h0;
	localparam logic [1:0] WRITE_MID   = 2'h2;
	localparam logic [5:0] READ_OPC    = 6'h0F;
	localparam logic [5:0] WRITE_ALL   = 6'h29;
	localparam logic [5:0] WRITE_FLG   = 6'h28;
	localparam logic [3:0] ONES_FIELD  = 4'hF;
	localparam int unsigned TARGET_BIT = 22;
	localparam int unsigned IMM_BIT    = 25;

	// ----------------------------------------------------------------
	// Register port map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_CUR   = 8'h04;
	localparam logic [7:0] ADDR_SAVED = 8'h08;
	localparam logic [7:0] ADDR_COUNT = 8'h0C;
	localparam logic       CTRL_RESET = 1'b1;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Condition field test against the current N, Z, C, V flags.
	function automatic logic cond_pass(input logic [3:0] cond, input logic [3:0] nzcv);
		logic n, z, c, v;
		n = nzcv[3];
		z = nzcv[2];
		c = nzcv[1];
		v = nzcv[0];
		unique case (cond)
			4'h0: return z;
			4'h1: return !z;
			4'h2: return c;
			4'h3: return !c;
			4'h4: return n;
			4'h5: return !n;
			4'h6: return v;
			4'h7: return !v;
			4'h8: return c && !z;
			4'h9: return !c || z;
			4'hA: return n == v;
			4'hB: return n != v;
			4'hC: return !z && (n == v);
			4'hD: return z || (n != v);
			4'hE: return 1'b1;
			4'hF: return 1'b0;
		endcase
	endfunction : cond_pass

	// Rotated 8-bit immediate: value rotated right by twice the rotate field.
	function automatic logic [31:0] rot_imm(input logic [11:0] field);
		logic [31:0] v;
		logic [5:0]  r;
		v = {24'h00_0000, field[7:0]};
		r = {1'b0, field[11:8], 1'b0};
		return (v >> r) | (v << (6'h20 - r));
	endfunction : rot_imm

	// Maps a mode to its saved-word bank; bit 3 flags a mode that owns one.
	function automatic logic [3:0] bank_of(input logic [4:0] mode);
		unique case (mode)
			MODE_FIQ:   return 4'h8;
			MODE_IRQ:   return 4'h9;
			MODE_SVC:   return 4'hA;
			MODE_ABORT: return 4'hB;
			MODE_UNDEF: return 4'hC;
			default:    return 4'h0;
		endcase
	endfunction : bank_of

endpackage : status_xfer_pkg

//--- rtl/status_xfer_exec.sv
/*
 * Execution unit for the status-word transfer instructions, with an AXI4-Lite
 * register port for control and observation.
 * Assumes the instruction and the source register value arrive on clk_sys from core logic.
 */
// Design decisions made here: the address map and the AXI4-Lite register port.

// Function
// RULE1 - Twelve defined status bits, rest reserved
// RULE2 - Software ignores reserved bit values
// RULE3 - Software preserves reserved bits on writes
// RULE4 - Read copies whole selected status word
// RULE5 - Low five bits are mode, write switches
// RULE6 - Flag write leaves control bits alone
// RULE7 - Immediate flag write sets flags outright
// RULE8 - Software avoids full immediate status writes
// RULE9 - Every transfer completes in one cycle
// RULE10 - Top four source bits feed N Z C V
// RULE11 - User mode full write touches flags only
// RULE12 - Privileged full write replaces whole word
// RULE13 - Bit 22 target, bit 25 immediate
// RULE14 - Execute only when condition passes
module status_xfer_exec (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        instr_valid,
	input  wire logic [31:0] instr_word,
	input  wire logic [31:0] source_general_reg,
	output logic             gr_we,
	output logic [3:0]       gr_addr,
	output logic [31:0]      gr_data,
	output logic             instr_done,
	output logic             cond_passed,
	output logic [31:0]      current_status_word,
	output logic [31:0]      saved_status_word,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic [31:0] cur_r;
	logic [31:0] saved_r [status_xfer_pkg::NUM_BANKS];
	logic        enable_r;
	logic [31:0] count_r;
	logic [3:0]  bank;
	logic [2:0]  bank_idx;
	logic        bank_ok;
	logic        user_mode;
	logic        cond_ok;
	logic        is_read;
	logic        is_all;
	logic        is_flg;
	logic        go;
	logic        to_saved;
	logic        exec_rd;
	logic        exec_all;
	logic        exec_flg;
	logic [31:0] src_val;
	logic [31:0] saved_sel;

	// RULE1 mode field decode
	assign bank      = status_xfer_pkg::bank_of(cur_r[status_xfer_pkg::MODE_HI:0]);
	assign bank_ok   = bank[3];
	assign bank_idx  = bank[2:0];
	assign user_mode = cur_r[status_xfer_pkg::MODE_HI:0] == status_xfer_pkg::MODE_USER;
	assign saved_sel = bank_ok ? saved_r[bank_idx] : cur_r;

	// RULE14 condition check
	assign cond_ok = status_xfer_pkg::cond_pass(instr_word[31:28],
		cur_r[status_xfer_pkg::FLAG_HI:status_xfer_pkg::FLAG_LO]);

	assign is_read = instr_word[27:23] == status_xfer_pkg::READ_CLASS
		&& instr_word[21:16] == status_xfer_pkg::READ_OPC && instr_word[11:0] == 12'h000;
	assign is_all = instr_word[27:26] == status_xfer_pkg::WRITE_HI
		&& instr_word[24:23] == status_xfer_pkg::WRITE_MID
		&& instr_word[21:16] == status_xfer_pkg::WRITE_ALL
		&& instr_word[15:12] == status_xfer_pkg::ONES_FIELD
		&& (instr_word[status_xfer_pkg::IMM_BIT] || instr_word[11:4] == 8'h00);
	assign is_flg = instr_word[27:26] == status_xfer_pkg::WRITE_HI
		&& instr_word[24:23] == status_xfer_pkg::WRITE_MID
		&& instr_word[21:16] == status_xfer_pkg::WRITE_FLG
		&& instr_word[15:12] == status_xfer_pkg::ONES_FIELD
		&& (instr_word[status_xfer_pkg::IMM_BIT] || instr_word[11:4] == 8'h00);

	// RULE13 target and source select
	assign to_saved = instr_word[status_xfer_pkg::TARGET_BIT];
	assign src_val  = instr_word[status_xfer_pkg::IMM_BIT]
		? status_xfer_pkg::rot_imm(instr_word[11:0]) : source_general_reg;

	assign go       = instr_valid && enable_r && cond_ok;
	assign exec_rd  = go && is_read;
	assign exec_all = go && is_all;
	assign exec_flg = go && is_flg;

	// ----------------------------------------------------------------
	// Status words
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			cur_r <= status_xfer_pkg::CUR_RESET;
		end else if (exec_all && !to_saved && !user_mode) begin
			// RULE12 privileged full write
			// RULE5 mode switch
			cur_r <= src_val;
		end else if ((exec_all && !to_saved) || (exec_flg && !to_saved)) begin
			// RULE11 user mode protection
			// RULE6 flags only
			// RULE10 top bits to flags
			cur_r[status_xfer_pkg::FLAG_HI:status_xfer_pkg::FLAG_LO] <=
				src_val[status_xfer_pkg::FLAG_HI:status_xfer_pkg::FLAG_LO];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			for (int i = 0; i < status_xfer_pkg::NUM_BANKS; i++) begin
				saved_r[i] <= status_xfer_pkg::SAVED_RESET;
			end
		end else if (exec_all && to_saved && bank_ok) begin
			// RULE12 saved word of current mode
			saved_r[bank_idx] <= src_val;
		end else if (exec_flg && to_saved && bank_ok) begin
			// RULE7 immediate sets flags outright
			saved_r[bank_idx][status_xfer_pkg::FLAG_HI:status_xfer_pkg::FLAG_LO] <=
				src_val[status_xfer_pkg::FLAG_HI:status_xfer_pkg::FLAG_LO];
		end
	end

	assign current_status_word = cur_r;
	assign saved_status_word   = saved_sel;

	// ----------------------------------------------------------------
	// Result and completion
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			gr_we   <= 1'b0;
			gr_addr <= 4'h0;
			gr_data <= 32'h0000_0000;
		end else begin
			// RULE4 full word copy
			gr_we   <= exec_rd;
			gr_addr <= instr_word[15:12];
			gr_data <= to_saved ? saved_sel : cur_r;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			instr_done  <= 1'b0;
			cond_passed <= 1'b0;
		end else begin
			// RULE9 single cycle
			instr_done  <= instr_valid;
			cond_passed <= go;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			count_r <= 32'h0000_0000;
		end else if (exec_rd || exec_all || exec_flg) begin
			count_r <= count_r + 32'h0000_0001;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic       aw_held_r;
	logic       w_held_r;
	logic [7:0] waddr_r;
	logic [31:0] wdata_r;
	logic       wlane0_r;

	function automatic logic addr_known(input logic [7:0] a);
		return a == status_xfer_pkg::ADDR_CTRL || a == status_xfer_pkg::ADDR_CUR
			|| a == status_xfer_pkg::ADDR_SAVED || a == status_xfer_pkg::ADDR_COUNT;
	endfunction : addr_known

	assign awready = !aw_held_r && !bvalid;
	assign wready  = !w_held_r && !bvalid;
	assign arready = !rvalid;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			waddr_r   <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			wlane0_r  <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= status_xfer_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held_r <= 1'b1;
				waddr_r   <= awaddr;
			end
			if (wvalid && wready) begin
				w_held_r <= 1'b1;
				wdata_r  <= wdata;
				wlane0_r <= wstrb[0];
			end
			if (aw_held_r && w_held_r && !bvalid) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid    <= 1'b1;
				bresp     <= addr_known(waddr_r) ? status_xfer_pkg::RESP_OKAY
					: status_xfer_pkg::RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			enable_r <= status_xfer_pkg::CTRL_RESET;
		end else if (aw_held_r && w_held_r && !bvalid && wlane0_r
			&& waddr_r == status_xfer_pkg::ADDR_CTRL) begin
			enable_r <= wdata_r[0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= status_xfer_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= addr_known(araddr) ? status_xfer_pkg::RESP_OKAY
				: status_xfer_pkg::RESP_SLVERR;
			unique case (araddr)
				status_xfer_pkg::ADDR_CTRL:  rdata <= {31'h0000_0000, enable_r};
				status_xfer_pkg::ADDR_CUR:   rdata <= cur_r;
				status_xfer_pkg::ADDR_SAVED: rdata <= saved_sel;
				status_xfer_pkg::ADDR_COUNT: rdata <= count_r;
				default:                     rdata <= 32'h0000_0000;
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence priv_cur_write_s;
		exec_all && !to_saved && !user_mode;
	endsequence
	sequence user_cur_write_s;
		exec_all && !to_saved && user_mode;
	endsequence

	read_copy_a: assert property (exec_rd |=> gr_we // RULE4
		&& gr_data == ($past(to_saved) ? $past(saved_sel) : $past(cur_r)))
		else $error("read transfer did not copy the status word");
	mode_switch_a: assert property (priv_cur_write_s |=> cur_r[4:0] == $past(src_val[4:0])) // RULE5
		else $error("mode field not taken from full write");
	flag_keep_a: assert property (exec_flg && !to_saved |=> cur_r[27:0] == $past(cur_r[27:0])) // RULE6
		else $error("flag write disturbed control bits");
	flag_imm_a: assert property (exec_flg && !to_saved && instr_word[25] // RULE7
		|=> cur_r[31:28] == $past(src_val[31:28]))
		else $error("immediate flag write wrong");
	one_cycle_a: assert property (instr_valid |=> instr_done // RULE9
		##1 instr_done == $past(instr_valid))
		else $error("transfer did not finish in one cycle");
	flag_order_a: assert property (exec_flg && !to_saved && !instr_word[25] // RULE10
		|=> cur_r[31] == $past(source_general_reg[31]) && cur_r[28] == $past(source_general_reg[28]))
		else $error("flags not taken in N Z C V order");
	user_guard_a: assert property (user_cur_write_s |=> cur_r[27:0] == $past(cur_r[27:0])) // RULE11
		else $error("user mode full write changed control bits");
	priv_full_a: assert property (priv_cur_write_s |=> cur_r == $past(src_val)) // RULE12
		else $error("privileged full write incomplete");
	target_sel_a: assert property (go && to_saved && !is_read |=> $stable(cur_r)) // RULE13
		else $error("saved target write changed current word");
	cond_fail_a: assert property (instr_valid && !cond_ok |=> $stable(cur_r) && !gr_we) // RULE14
		else $error("failed condition still had an effect");

endmodule : status_xfer_exec

//--- tb/tb_top.sv
/*
 * Self-checking bench for the status-word transfer unit and its register port.
 * Assumes the bench alone drives every input; no far-side model is used.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys = 1'b0, reset_n = 1'b0, instr_valid = 1'b0;
	logic [31:0] instr_word = 32'h0, source_general_reg = 32'h0;
	logic        gr_we, instr_done, cond_passed;
	logic [3:0]  gr_addr;
	logic [31:0] gr_data, current_status_word, saved_status_word;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	int          bad_count = 0, check_count = 0;

	status_xfer_exec dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .instr_valid(instr_valid),
		.instr_word(instr_word), .source_general_reg(source_general_reg), .gr_we(gr_we),
		.gr_addr(gr_addr), .gr_data(gr_data), .instr_done(instr_done),
		.cond_passed(cond_passed), .current_status_word(current_status_word),
		.saved_status_word(saved_status_word), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	always #20 clk_sys = ~clk_sys;

	// ----------------------------------------------------------------
	// Shared checks and bus cycles
	// ----------------------------------------------------------------
	task automatic summarize();
		if (bad_count == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tmo(input int n);
		if (n >= 20) begin
			bad_count++;
			summarize();
		end
	endtask : tmo

	// Offers one instruction; the answer is looked at in the cycle after the taking edge.
	task automatic issue(input logic [31:0] i, input logic [31:0] s, input logic go,
			input logic [31:0] exp_cur);
		logic rd;
		rd = (i[27:23] == 5'h02) && (i[21:16] == 6'h0F);
		instr_valid <= 1'b1;
		instr_word <= i;
		source_general_reg <= s;
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		#1;
		chk({31'h0, instr_done}, 32'h1);
		chk({31'h0, cond_passed}, {31'h0, go});
		chk({31'h0, gr_we}, {31'h0, go && rd});
		chk(current_status_word, exp_cur);
	endtask : issue

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int  n;
		logic ap, wp;
		ap = 1'b1;
		wp = 1'b1;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (n = 0; n < 20 && (ap || wp); n++) begin
			@(posedge clk_sys);
			if (ap && awready === 1'b1) begin
				ap = 1'b0;
				awvalid <= 1'b0;
			end
			if (wp && wready === 1'b1) begin
				wp = 1'b0;
				wvalid <= 1'b0;
			end
		end
		tmo(n);
		bready <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk_sys);
			if (bvalid === 1'b1) break;
		end
		tmo(n);
		chk({30'h0, bresp}, {30'h0, er});
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk_sys);
			if (arready === 1'b1) break;
		end
		tmo(n);
		arvalid <= 1'b0;
		rready <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk_sys);
			if (rvalid === 1'b1) break;
		end
		tmo(n);
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
		rready <= 1'b0;
	endtask : axi_rd

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk(current_status_word, status_xfer_pkg::CUR_RESET);
		chk(saved_status_word, status_xfer_pkg::SAVED_RESET);
		axi_rd(status_xfer_pkg::ADDR_CTRL, 32'h0000_0001, status_xfer_pkg::RESP_OKAY);
		axi_rd(8'h10, 32'h0000_0000, status_xfer_pkg::RESP_SLVERR);
		axi_wr(8'h10, 32'h0000_0000, status_xfer_pkg::RESP_SLVERR);
	endtask : t_reset

	// Flag-only writes back to back with a read that must see the new flags.
	task automatic t_flags();
		issue(32'hE328_F4A0, 32'h0, 1'b1, 32'hA000_00D3);
		issue(32'hE10F_2000, 32'h0, 1'b1, 32'hA000_00D3);
		chk({28'h0, gr_addr}, 32'h2);
		chk(gr_data, 32'hA000_00D3);
		issue(32'hE128_F000, 32'h5FFF_FF00, 1'b1, 32'h5000_00D3);
	endtask : t_flags

	task automatic t_full();
		issue(32'hE129_F000, 32'h3000_0F11, 1'b1, 32'h3000_0F11);
		chk(saved_status_word, 32'h0);
		chk(current_status_word & status_xfer_pkg::DEFINED_MASK, 32'h3000_0011);
		issue(32'hE169_F000, 32'h8000_0013, 1'b1, 32'h3000_0F11);
		chk(saved_status_word, 32'h8000_0013);
		issue(32'hE14F_3000, 32'h0, 1'b1, 32'h3000_0F11);
		chk(gr_data, 32'h8000_0013);
		issue(32'hE368_F4C0, 32'h0, 1'b1, 32'h3000_0F11);
		chk(saved_status_word, 32'hC000_0013);
	endtask : t_full

	task automatic t_cond();
		issue(32'h0328_F4A0, 32'h0, 1'b0, 32'h3000_0F11);
		issue(32'h2328_F000, 32'h0, 1'b1, 32'h0000_0F11);
		issue(32'hF328_F4A0, 32'h0, 1'b0, 32'h0000_0F11);
	endtask : t_cond

	task automatic t_ctrl();
		axi_wr(status_xfer_pkg::ADDR_CTRL, 32'h0, status_xfer_pkg::RESP_OKAY);
		axi_rd(status_xfer_pkg::ADDR_CTRL, 32'h0, status_xfer_pkg::RESP_OKAY);
		issue(32'hE328_F4A0, 32'h0, 1'b0, 32'h0000_0F11);
		axi_wr(status_xfer_pkg::ADDR_CTRL, 32'h1, status_xfer_pkg::RESP_OKAY);
		axi_wr(status_xfer_pkg::ADDR_CUR, 32'h0, status_xfer_pkg::RESP_OKAY);
		axi_rd(status_xfer_pkg::ADDR_CUR, 32'h0000_0F11, status_xfer_pkg::RESP_OKAY);
		axi_rd(status_xfer_pkg::ADDR_SAVED, 32'hC000_0013, status_xfer_pkg::RESP_OKAY);
		axi_rd(status_xfer_pkg::ADDR_COUNT, 32'h0000_0008, status_xfer_pkg::RESP_OKAY);
	endtask : t_ctrl

	// User mode protects control bits and has no saved word of its own.
	task automatic t_user();
		@(posedge clk_sys);
		#1;
		issue(32'hE129_F000, 32'h0000_0010, 1'b1, 32'h0000_0010);
		chk(saved_status_word, 32'h0000_0010);
		issue(32'hE129_F000, 32'hF000_00D3, 1'b1, 32'hF000_0010);
		issue(32'hE14F_4000, 32'h0, 1'b1, 32'hF000_0010);
		chk(gr_data, 32'hF000_0010);
		issue(32'hE129_F000, {4'h9, gr_data[27:0]}, 1'b1, 32'h9000_0010);
		issue(32'hE328_F4A0, 32'h0, 1'b1, 32'hA000_0010);
	endtask : t_user

	initial begin
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		t_reset();
		@(posedge clk_sys);
		#1;
		t_flags();
		t_full();
		t_cond();
		t_ctrl();
		t_user();
		summarize();
	end
endmodule : tb_top
